// >>> inc/cfs_map.svh
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH

// Clock and common time base
`define CFS_CLK_NS 100
`define CFS_TICK_CYC 100
`define CFS_TICK_US ((`CFS_TICK_CYC * `CFS_CLK_NS) / 1000)

// Protection times in microseconds
`define CFS_INOC_BLANK_US 2500
`define CFS_INOC_HOLD_US 1300000
`define CFS_INOC_WINDOW_US 90000000
`define CFS_OVP_KILL_US 30000
`define CFS_BATLOW_PAUSE_US 1000
`define CFS_SS_STEP_US 240

// Switch short blanking after turn-on, in nanoseconds
`define CFS_SHORT_BLANK_NS 300

// Event count that latches a path off
`define CFS_EVENT_LIMIT 3'h7

// Option word field positions
`define CFS_OPT_INHIBIT 0
`define CFS_OPT_INOC_LSB 1
`define CFS_OPT_INOC_MSB 2
`define CFS_OPT_HSS_LSB 7
`define CFS_OPT_HSS_MSB 8
`define CFS_OPT_TRIM_EN 9
`define CFS_OPT_TRIM_UP 10

// Input over-current threshold codes
`define CFS_INOC_OFF 2'h0
`define CFS_INOC_X133 2'h1
`define CFS_INOC_X166 2'h2
`define CFS_INOC_X222 2'h3

// Peak charge over-current levels, current codes in 64 mA units
`define CFS_POCP_6A 2'h0
`define CFS_POCP_9A 2'h1
`define CFS_POCP_12A 2'h2
`define CFS_POCP_6A_MAX 7'h2F
`define CFS_POCP_9A_MAX 7'h5F

// Soft-start start level, step and low-battery cap
`define CFS_SS_START 7'h02
`define CFS_SS_STEP 7'h01
`define CFS_BATLOW_CAP 7'h07

`endif

// >>> inc/cfs_pkg.sv
`default_nettype none

package cfs_pkg;

  // Charge current code, 64 mA per step
  typedef logic [6:0] cfs_cur_code_t;

  // Input over-current supervisor states, Gray along the path
  typedef enum logic [1:0] {
    CFS_INOC_IDLE = 2'h0,
    CFS_INOC_BLANK = 2'h1,
    CFS_INOC_HOLD = 2'h3,
    CFS_INOC_LATCH = 2'h2
  } cfs_inoc_state_t;

endpackage : cfs_pkg

`default_nettype wire

// >>> design/cfs_timer.sv
`timescale 1ns/100ps
`default_nettype none

module cfs_timer #(
  parameter int unsigned W = 24,
  parameter logic [W-1:0] LIMIT = '1
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clr_i,
  input wire logic run_i,
  input wire logic tick_i,
  output logic done_o
);

  logic [W-1:0] count;

  // Counts time-base ticks while running, holds at the limit
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= '0;
    end else if (clr_i || !run_i) begin
      count <= '0;
    end else if (tick_i && (count != LIMIT)) begin
      count <= count + W'(1);
    end
  end

  // Expiry level, stays high until cleared or stopped
  assign done_o = run_i && (count == LIMIT);

endmodule : cfs_timer

`default_nettype wire

// >>> design/cfs_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`include "cfs_map.svh"

module cfs_supervisor #(
  parameter int unsigned TW = 24,
  parameter int unsigned INOC_BLANK_TICKS = (`CFS_INOC_BLANK_US + `CFS_TICK_US - 1) / `CFS_TICK_US,
  parameter int unsigned INOC_HOLD_TICKS = (`CFS_INOC_HOLD_US + `CFS_TICK_US - 1) / `CFS_TICK_US,
  parameter int unsigned INOC_WINDOW_TICKS = `CFS_INOC_WINDOW_US / `CFS_TICK_US,
  parameter int unsigned OVP_KILL_TICKS = (`CFS_OVP_KILL_US + `CFS_TICK_US - 1) / `CFS_TICK_US,
  parameter int unsigned BATLOW_PAUSE_TICKS = (`CFS_BATLOW_PAUSE_US + `CFS_TICK_US - 1) / `CFS_TICK_US,
  parameter int unsigned SS_STEP_TICKS = `CFS_SS_STEP_US / `CFS_TICK_US,
  parameter int unsigned SHORT_BLANK_CYC = (`CFS_SHORT_BLANK_NS + `CFS_CLK_NS - 1) / `CFS_CLK_NS
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic input_overcurrent_fault_i,
  input wire logic charge_peak_overcurrent_i,
  input wire logic battery_overvoltage_fault_i,
  input wire logic battery_low_fault_i,
  input wire logic thermal_shutdown_fault_i,
  input wire logic high_side_short_i,
  input wire logic low_side_short_i,
  input wire logic undervoltage_lockout_i,
  input wire logic adapter_detect_low_i,
  input wire logic cycle_start_i,
  input wire logic high_side_on_i,
  input wire logic low_side_on_i,
  input wire logic bootstrap_refresh_i,
  input wire logic [15:0] charge_option_control_i,
  input wire cfs_pkg::cfs_cur_code_t charge_current_code_i,
  output logic adapter_input_switch_on_o,
  output logic reverse_block_switch_on_o,
  output logic battery_path_switch_on_o,
  output logic high_side_switch_en_o,
  output logic low_side_switch_en_o,
  output logic discharge_sink_en_o,
  output logic gate_drive_regulator_low_limit_o,
  output logic charge_enable_o,
  output cfs_pkg::cfs_cur_code_t charge_current_limit_o,
  output logic [1:0] input_overcurrent_sel_o,
  output logic [1:0] charge_peak_overcurrent_sel_o,
  output logic [1:0] high_side_short_sel_o,
  output logic freq_trim_en_o,
  output logic freq_trim_up_o,
  output logic input_overcurrent_latched_o,
  output logic short_circuit_latched_o
);
  import cfs_pkg::*;

  localparam int unsigned NSYNC = 9;
  localparam logic [6:0] TICK_LAST = 7'(`CFS_TICK_CYC - 1);
  localparam logic [7:0] SHORT_BLANK_LAST = 8'(SHORT_BLANK_CYC);

  logic [NSYNC-1:0] flag_meta;
  logic [NSYNC-1:0] flag_sync;
  logic [6:0] tick_cnt;
  logic tick;
  wire iocp_s, pocp_s, ovp_s, blow_s, hot_s, hss_s, lss_s, undervoltage_lockout_s, adet_low_s;

  // Two-stage synchronisers for every comparator flag
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_meta <= '0;
      flag_sync <= '0;
    end else begin
      flag_meta <= {adapter_detect_low_i, undervoltage_lockout_i, low_side_short_i, high_side_short_i,
                    thermal_shutdown_fault_i, battery_low_fault_i, battery_overvoltage_fault_i,
                    charge_peak_overcurrent_i, input_overcurrent_fault_i};
      flag_sync <= flag_meta;
    end
  end

  assign {adet_low_s, undervoltage_lockout_s, lss_s, hss_s, hot_s, blow_s, ovp_s, pocp_s, iocp_s} = flag_sync;

  // Common time-base tick for all long timers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt <= 7'h00;
      tick <= 1'b0;
    end else begin
      tick_cnt <= (tick_cnt == TICK_LAST) ? 7'h00 : tick_cnt + 7'h01;
      tick <= (tick_cnt == TICK_LAST);
    end
  end

  // Option decode and supervisor reset condition
  wire reset_cond = undervoltage_lockout_s || adet_low_s;
  wire [1:0] inoc_code = charge_option_control_i[`CFS_OPT_INOC_MSB:`CFS_OPT_INOC_LSB];
  wire inoc_en = (inoc_code != `CFS_INOC_OFF);
  wire opt_inhibit = charge_option_control_i[`CFS_OPT_INHIBIT];
  wire trim_en = charge_option_control_i[`CFS_OPT_TRIM_EN];
  wire trim_up = charge_option_control_i[`CFS_OPT_TRIM_UP];
  wire [1:0] hss_code = charge_option_control_i[`CFS_OPT_HSS_MSB:`CFS_OPT_HSS_LSB];

  cfs_inoc_state_t inoc_state, next_inoc_state;
  logic [2:0] inoc_events, next_inoc_events;
  logic blank_done, hold_done, window_done;

  // Input over-current timers
  cfs_timer #(.W(TW), .LIMIT(TW'(INOC_BLANK_TICKS))) u_inoc_blank (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clr_i(reset_cond),
    .run_i(inoc_state == CFS_INOC_BLANK), .tick_i(tick), .done_o(blank_done)
  );
  cfs_timer #(.W(TW), .LIMIT(TW'(INOC_HOLD_TICKS))) u_inoc_hold (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clr_i(reset_cond),
    .run_i(inoc_state == CFS_INOC_HOLD), .tick_i(tick), .done_o(hold_done)
  );
  cfs_timer #(.W(TW), .LIMIT(TW'(INOC_WINDOW_TICKS))) u_inoc_window (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clr_i(reset_cond || window_done),
    .run_i(inoc_events != 3'h0), .tick_i(tick), .done_o(window_done)
  );

  // Input over-current state and event count
  always_comb begin
    next_inoc_state = inoc_state;
    next_inoc_events = inoc_events;
    if (window_done) begin
      next_inoc_events = 3'h0;
    end
    case (inoc_state)
      CFS_INOC_IDLE: begin
        if (inoc_en && iocp_s) begin
          next_inoc_state = CFS_INOC_BLANK;
        end
      end
      CFS_INOC_BLANK: begin
        if (!inoc_en || !iocp_s) begin
          next_inoc_state = CFS_INOC_IDLE;
        end else if (blank_done) begin
          next_inoc_events = next_inoc_events + 3'h1;
          next_inoc_state = (next_inoc_events == `CFS_EVENT_LIMIT) ? CFS_INOC_LATCH : CFS_INOC_HOLD;
        end
      end
      CFS_INOC_HOLD: begin
        if (hold_done && !iocp_s) begin
          next_inoc_state = CFS_INOC_IDLE;
        end
      end
      CFS_INOC_LATCH: begin
        next_inoc_state = CFS_INOC_LATCH;
      end
      default: begin
        next_inoc_state = CFS_INOC_IDLE;
      end
    endcase
    if (reset_cond) begin
      next_inoc_state = CFS_INOC_IDLE;
      next_inoc_events = 3'h0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      inoc_state <= CFS_INOC_IDLE;
      inoc_events <= 3'h0;
    end else begin
      inoc_state <= next_inoc_state;
      inoc_events <= next_inoc_events;
    end
  end

  // Over-voltage persistence and battery-low pause
  logic ovp_kill, pause_done, blow_d, batlow_pause;

  cfs_timer #(.W(TW), .LIMIT(TW'(OVP_KILL_TICKS))) u_ovp_kill (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clr_i(reset_cond),
    .run_i(ovp_s), .tick_i(tick), .done_o(ovp_kill)
  );
  cfs_timer #(.W(TW), .LIMIT(TW'(BATLOW_PAUSE_TICKS))) u_batlow_pause (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clr_i(reset_cond || pause_done),
    .run_i(batlow_pause), .tick_i(tick), .done_o(pause_done)
  );

  // Pause starts on battery-low entry, a new entry wins over expiry
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blow_d <= 1'b0;
      batlow_pause <= 1'b0;
    end else begin
      blow_d <= blow_s;
      if (reset_cond) begin
        batlow_pause <= 1'b0;
      end else if (blow_s && !blow_d) begin
        batlow_pause <= 1'b1;
      end else if (pause_done) begin
        batlow_pause <= 1'b0;
      end
    end
  end

  // Switch short detection, one counter per switch
  logic [1:0] side_on, side_cmp, short_full;
  assign side_on = {low_side_on_i, high_side_on_i};
  assign side_cmp = {lss_s, hss_s};

  for (genvar g = 0; g < 2; g++) begin : g_short
    logic [7:0] blank;
    logic seen;
    logic [2:0] events;
    wire hit = side_on[g] && (blank == SHORT_BLANK_LAST) && side_cmp[g] && !seen;

    // Blanking after turn-on, one count per on-period
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        blank <= 8'h00;
        seen <= 1'b0;
        events <= 3'h0;
      end else if (reset_cond) begin
        blank <= 8'h00;
        seen <= 1'b0;
        events <= 3'h0;
      end else begin
        if (!side_on[g]) begin
          blank <= 8'h00;
          seen <= 1'b0;
        end else if (blank != SHORT_BLANK_LAST) begin
          blank <= blank + 8'h01;
        end
        if (hit) begin
          seen <= 1'b1;
          events <= (events == `CFS_EVENT_LIMIT) ? events : events + 3'h1;
        end
      end
    end

    assign short_full[g] = (events == `CFS_EVENT_LIMIT);
  end

  wire short_latch = |short_full;
  wire inoc_off = (inoc_state == CFS_INOC_HOLD) || (inoc_state == CFS_INOC_LATCH);
  wire adapter_on = !(reset_cond || inoc_off || short_latch);
  wire charge_ok = adapter_on && !opt_inhibit && !ovp_kill && !hot_s && !batlow_pause;

  // Soft-start step timer and current ramp
  logic step_done;
  cfs_cur_code_t ss_code;

  cfs_timer #(.W(TW), .LIMIT(TW'(SS_STEP_TICKS))) u_ss_step (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clr_i(reset_cond || step_done),
    .run_i(charge_ok && (ss_code < charge_current_code_i)), .tick_i(tick), .done_o(step_done)
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ss_code <= `CFS_SS_START;
    end else if (!charge_ok) begin
      ss_code <= `CFS_SS_START;
    end else if (ss_code > charge_current_code_i) begin
      ss_code <= charge_current_code_i;
    end else if (step_done) begin
      ss_code <= ss_code + `CFS_SS_STEP;
    end
  end

  // Peak over-current blocks high side for the rest of the cycle
  logic pocp_hold;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pocp_hold <= 1'b0;
    end else if (pocp_s) begin
      pocp_hold <= 1'b1;
    end else if (cycle_start_i) begin
      pocp_hold <= 1'b0;
    end
  end

  // Next values for the registered outputs
  wire next_hs_en = charge_ok && !ovp_s && !pocp_s && !pocp_hold;
  wire next_ls_en = charge_ok && !ovp_s && (!blow_s || bootstrap_refresh_i);
  wire [6:0] next_limit = (blow_s && (ss_code > `CFS_BATLOW_CAP)) ? `CFS_BATLOW_CAP : ss_code;
  wire [1:0] next_pocp_sel = (charge_current_code_i <= `CFS_POCP_6A_MAX) ? `CFS_POCP_6A :
                             (charge_current_code_i <= `CFS_POCP_9A_MAX) ? `CFS_POCP_9A : `CFS_POCP_12A;

  // Power path and converter drive outputs
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      adapter_input_switch_on_o <= 1'b0;
      reverse_block_switch_on_o <= 1'b0;
      battery_path_switch_on_o <= 1'b0;
      high_side_switch_en_o <= 1'b0;
      low_side_switch_en_o <= 1'b0;
      charge_enable_o <= 1'b0;
      charge_current_limit_o <= `CFS_SS_START;
    end else begin
      adapter_input_switch_on_o <= adapter_on;
      reverse_block_switch_on_o <= adapter_on;
      battery_path_switch_on_o <= !adapter_on;
      high_side_switch_en_o <= next_hs_en;
      low_side_switch_en_o <= next_ls_en;
      charge_enable_o <= charge_ok;
      charge_current_limit_o <= next_limit;
    end
  end

  // Protection status, threshold selects and trim outputs
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      discharge_sink_en_o <= 1'b0;
      gate_drive_regulator_low_limit_o <= 1'b0;
      input_overcurrent_sel_o <= `CFS_INOC_OFF;
      charge_peak_overcurrent_sel_o <= `CFS_POCP_6A;
      high_side_short_sel_o <= 2'h0;
      freq_trim_en_o <= 1'b0;
      freq_trim_up_o <= 1'b0;
      input_overcurrent_latched_o <= 1'b0;
      short_circuit_latched_o <= 1'b0;
    end else begin
      discharge_sink_en_o <= ovp_s;
      gate_drive_regulator_low_limit_o <= hot_s;
      input_overcurrent_sel_o <= inoc_code;
      charge_peak_overcurrent_sel_o <= next_pocp_sel;
      high_side_short_sel_o <= hss_code;
      freq_trim_en_o <= trim_en;
      freq_trim_up_o <= trim_en && trim_up;
      input_overcurrent_latched_o <= (inoc_state == CFS_INOC_LATCH);
      short_circuit_latched_o <= short_latch;
    end
  end

endmodule : cfs_supervisor

`default_nettype wire

// >>> verification/cfs_pwm_model.sv
`timescale 1ns/100ps
`default_nettype none

module cfs_pwm_model #(
  parameter int PERIOD = 20
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic hs_en_i,
  input wire logic ls_en_i,
  output logic cycle_start_o,
  output logic hs_on_o,
  output logic ls_on_o,
  output logic refresh_o
);
  logic [7:0] cnt;

  // Free-running switching period
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 8'h00;
    end else begin
      cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
    end
  end

  // High side first, dead cycle, then low side; refresh request at period end
  assign cycle_start_o = (cnt == 8'h00);
  assign hs_on_o = hs_en_i && cnt >= 8'h01 && cnt <= 8'(PERIOD / 2);
  assign ls_on_o = ls_en_i && cnt > 8'(PERIOD / 2 + 1) && cnt < 8'(PERIOD - 1);
  assign refresh_o = (cnt == 8'(PERIOD - 1));
endmodule : cfs_pwm_model

`default_nettype wire

// >>> verification/cfs_supervisor_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "cfs_map.svh"

module cfs_supervisor_monitor (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic battery_overvoltage_fault_i,
  input wire logic thermal_shutdown_fault_i,
  input wire logic charge_peak_overcurrent_i,
  input wire logic battery_low_fault_i,
  input wire logic adapter_detect_low_i,
  input wire logic [15:0] charge_option_control_i,
  input wire cfs_pkg::cfs_cur_code_t charge_current_code_i,
  input wire logic high_side_switch_en_o,
  input wire logic low_side_switch_en_o,
  input wire logic discharge_sink_en_o,
  input wire logic gate_drive_regulator_low_limit_o,
  input wire logic charge_enable_o,
  input wire cfs_pkg::cfs_cur_code_t charge_current_limit_o,
  input wire logic [1:0] input_overcurrent_sel_o,
  input wire logic [1:0] charge_peak_overcurrent_sel_o,
  input wire logic [1:0] high_side_short_sel_o,
  input wire logic freq_trim_en_o,
  input wire logic freq_trim_up_o,
  input wire logic adapter_input_switch_on_o,
  input wire logic reverse_block_switch_on_o,
  input wire logic battery_path_switch_on_o,
  input wire logic input_overcurrent_latched_o,
  input wire logic short_circuit_latched_o
);
  import cfs_pkg::*;

  // Expected peak level and option alias
  wire [15:0] opt = charge_option_control_i;
  wire [1:0] exp_sel = (charge_current_code_i <= `CFS_POCP_6A_MAX) ? `CFS_POCP_6A :
    (charge_current_code_i <= `CFS_POCP_9A_MAX) ? `CFS_POCP_9A : `CFS_POCP_12A;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  ovp_gates_a: assert property ($past(battery_overvoltage_fault_i, 3) |->
    !high_side_switch_en_o && !low_side_switch_en_o) else $error("gates enabled in over-voltage");
  sink_match_a: assert property (
    discharge_sink_en_o == $past(battery_overvoltage_fault_i, 3)) else $error("sink mismatch");
  thermal_limit_a: assert property (
    gate_drive_regulator_low_limit_o == $past(thermal_shutdown_fault_i, 3)) else $error("regulator limit mismatch");
  thermal_off_a: assert property ($past(thermal_shutdown_fault_i, 3) |-> !charge_enable_o)
    else $error("charging during thermal stop");
  peak_cut_a: assert property ($past(charge_peak_overcurrent_i, 3) |-> !high_side_switch_en_o)
    else $error("high side on in peak over-current");
  opt_copy_a: assert property ($stable(opt) && $past(opt) == $past(opt, 2) && $past(arst_n_i, 2) |->
    {freq_trim_up_o, freq_trim_en_o, high_side_short_sel_o, input_overcurrent_sel_o} ==
    {opt[10] && opt[9], opt[9:7], opt[2:1]})
    else $error("option field mismatch");
  peak_sel_a: assert property ($stable(charge_current_code_i) && $past(arst_n_i, 2) |->
    charge_peak_overcurrent_sel_o == exp_sel) else $error("peak level mismatch");
  batlow_pause_a: assert property ($rose(battery_low_fault_i) |-> ##4 !charge_enable_o)
    else $error("no pause on battery low");
  batlow_cap_a: assert property (battery_low_fault_i [*5] |-> charge_current_limit_o <= `CFS_BATLOW_CAP)
    else $error("current not capped");
  latch_clear_a: assert property (adapter_detect_low_i [*5] |->
    !input_overcurrent_latched_o && !short_circuit_latched_o) else $error("latch not cleared");
  short_latch_a: assert property (short_circuit_latched_o && $past(short_circuit_latched_o) |->
    battery_path_switch_on_o && !adapter_input_switch_on_o && !reverse_block_switch_on_o)
    else $error("switches wrong in short latch");
  ioc_latch_a: assert property (input_overcurrent_latched_o && $past(input_overcurrent_latched_o) |->
    !adapter_input_switch_on_o && !reverse_block_switch_on_o) else $error("input switches on in latch");
endmodule : cfs_supervisor_monitor

bind cfs_supervisor cfs_supervisor_monitor mon_u (.*);

`default_nettype wire

// >>> verification/cfs_supervisor_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cfs_map.svh"

module cfs_supervisor_tb_top;
  import cfs_pkg::*;
  localparam int TK = `CFS_TICK_CYC;
  localparam int BLK = 3, HLD = 5, WIN = 120, OVK = 4, PAU = 3, STP = 2;
  logic ref_clk_i = 1'b0, arst_n_i = 1'b0;
  logic ioc = 1'b0, pk = 1'b0, ovp = 1'b0, blow = 1'b0, tsh = 1'b0;
  logic hss = 1'b0, lss = 1'b0, undervoltage_lockout = 1'b0, adl = 1'b0;
  logic [15:0] opt = 16'h0002;
  cfs_cur_code_t code = 7'h10;
  cfs_cur_code_t lim;
  logic cs, hon, lon, rfr, adp, rev, bat, hse, lse, snk, lol, chg, iol, scl, ten, tup;
  logic [1:0] ios, pks, hsl;
  logic [31:0] r;
  int bad_count = 0, checked = 0;
  int lo_q[$], w_q[$];
  logic [15:0] v_q[$];
  event chk_ev;
  cfs_cur_code_t pk_code[6] = '{7'h00, `CFS_POCP_6A_MAX, 7'h30, `CFS_POCP_9A_MAX, 7'h60, 7'h7F};
  logic [1:0] pk_sel[6] = '{`CFS_POCP_6A, `CFS_POCP_6A, `CFS_POCP_9A, `CFS_POCP_9A, `CFS_POCP_12A, `CFS_POCP_12A};
  wire [31:0] obs = {7'h00, scl, iol, tup, ten, hsl, pks, ios, lim, chg, lol, snk, lse, hse, bat, rev, adp};

  always #50 ref_clk_i = ~ref_clk_i;

  cfs_supervisor #(.INOC_BLANK_TICKS(BLK), .INOC_HOLD_TICKS(HLD), .INOC_WINDOW_TICKS(WIN),
    .OVP_KILL_TICKS(OVK), .BATLOW_PAUSE_TICKS(PAU), .SS_STEP_TICKS(STP)) dut_u (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .input_overcurrent_fault_i(ioc),
    .charge_peak_overcurrent_i(pk), .battery_overvoltage_fault_i(ovp), .battery_low_fault_i(blow),
    .thermal_shutdown_fault_i(tsh), .high_side_short_i(hss), .low_side_short_i(lss),
    .undervoltage_lockout_i(undervoltage_lockout), .adapter_detect_low_i(adl), .cycle_start_i(cs), .high_side_on_i(hon),
    .low_side_on_i(lon), .bootstrap_refresh_i(rfr), .charge_option_control_i(opt), .charge_current_code_i(code),
    .adapter_input_switch_on_o(adp), .reverse_block_switch_on_o(rev), .battery_path_switch_on_o(bat),
    .high_side_switch_en_o(hse), .low_side_switch_en_o(lse), .discharge_sink_en_o(snk),
    .gate_drive_regulator_low_limit_o(lol), .charge_enable_o(chg), .charge_current_limit_o(lim),
    .input_overcurrent_sel_o(ios), .charge_peak_overcurrent_sel_o(pks), .high_side_short_sel_o(hsl),
    .freq_trim_en_o(ten), .freq_trim_up_o(tup), .input_overcurrent_latched_o(iol), .short_circuit_latched_o(scl));

  cfs_pwm_model pwm_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .hs_en_i(hse), .ls_en_i(lse),
    .cycle_start_o(cs), .hs_on_o(hon), .ls_on_o(lon), .refresh_o(rfr));

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc

  // Note an expected field and flag it to the watcher
  task automatic expect_f(input int lo, input int w, input logic [15:0] v);
    @(negedge ref_clk_i);
    lo_q.push_back(lo);
    w_q.push_back(w);
    v_q.push_back(v);
    -> chk_ev;
    @(posedge ref_clk_i);
  endtask : expect_f

  task automatic compare_f(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare_f

  // Watcher takes every queued note, oldest first, whenever a result is flagged
  always @(chk_ev) begin
    while (v_q.size() > 0) begin
      compare_f((obs >> lo_q.pop_front()) & ((32'h1 << w_q.pop_front()) - 32'h1), {16'h0000, v_q.pop_front()});
    end
  end

  // One input over-current event, switches expected back on or latched off
  task automatic ioc_event(input logic on);
    ioc <= 1'b1;
    cyc((BLK + 2) * TK);
    expect_f(0, 2, 2'b00);
    ioc <= 1'b0;
    cyc((HLD + 2) * TK);
    expect_f(0, 2, {on, on});
  endtask : ioc_event

  task automatic print_verdict();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    void'($urandom(32'ha2bd));
    cyc(16);
    arst_n_i <= 1'b1;
    cyc(8);
    repeat (8) begin
      r = $urandom();
      opt <= r[15:0] & 16'hfffe;
      cyc(4);
      expect_f(15, 2, r[2:1]);
      expect_f(19, 2, r[8:7]);
      expect_f(21, 2, {r[10] & r[9], r[9]});
    end
    opt <= 16'h0002;
    foreach (pk_code[i]) begin
      code <= pk_code[i];
      cyc(3);
      expect_f(17, 2, pk_sel[i]);
    end
    code <= 7'h10;
    $display("test options finished");
    cyc(8);
    pk <= 1'b1;
    cyc(4);
    expect_f(3, 1, 1'b0);
    pk <= 1'b0;
    cyc(45);
    expect_f(3, 1, 1'b1);
    ovp <= 1'b1;
    cyc(4);
    expect_f(3, 3, 3'b100);
    cyc((OVK + 2) * TK);
    expect_f(7, 1, 1'b0);
    ovp <= 1'b0;
    cyc(4);
    expect_f(5, 1, 1'b0);
    tsh <= 1'b1;
    cyc(4);
    expect_f(6, 2, 2'b01);
    expect_f(8, 7, `CFS_SS_START);
    tsh <= 1'b0;
    cyc(32 * TK);
    expect_f(8, 7, 7'h10);
    blow <= 1'b1;
    cyc(4);
    expect_f(7, 1, 1'b0);
    cyc((PAU + 12) * TK);
    expect_f(8, 7, `CFS_BATLOW_CAP);
    blow <= 1'b0;
    cyc(40 * TK);
    expect_f(7, 8, {7'h10, 1'b1});
    $display("test faults finished");
    opt <= 16'h0000;
    ioc <= 1'b1;
    cyc((BLK + 3) * TK);
    expect_f(0, 2, 2'b11);
    ioc <= 1'b0;
    opt <= 16'h0002;
    cyc(8);
    repeat (6) ioc_event(1'b1);
    cyc(WIN * TK - 6 * 1202 + 5 * TK);
    repeat (6) ioc_event(1'b1);
    ioc_event(1'b0);
    expect_f(23, 1, 1'b1);
    adl <= 1'b1;
    cyc(6);
    adl <= 1'b0;
    cyc(4);
    expect_f(23, 1, 1'b0);
    $display("test input over-current finished");
    cyc(20);
    hss <= 1'b1;
    cyc(300);
    expect_f(0, 3, 3'b100);
    expect_f(24, 1, 1'b1);
    hss <= 1'b0;
    undervoltage_lockout <= 1'b1;
    cyc(6);
    undervoltage_lockout <= 1'b0;
    cyc(4);
    expect_f(24, 1, 1'b0);
    $display("test short latch finished");
    print_verdict();
  end

  // Watchdog well past the expected run length
  initial begin
    cyc(80000);
    bad_count++;
    print_verdict();
  end
endmodule : cfs_supervisor_tb_top

`default_nettype wire
